// file: rtl/lmc_pkg.sv
// Purpose: shared constants for the motor command decoder
// Assumes: byte-level frame interface from a bit-level transceiver
// Notes: identifiers are the 6-bit frame identifiers without parity bits
package lmc_pkg;
	localparam logic [5:0] ID_PREP = 6'h3C;
	localparam logic [5:0] ID_READ = 6'h3D;
	localparam logic [7:0] APP_CMD = 8'h80;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [6:0] CMD_OTP = 7'h02;
	localparam logic [6:0] CMD_SECURE = 7'h04;
	localparam logic [6:0] CMD_STOP = 7'h05;
	localparam logic [6:0] CMD_CLEAR = 7'h06;
	localparam logic [3:0] LEN_PREP = 4'h8;
	localparam logic [3:0] LEN_SHORT = 4'h2;
	localparam logic [3:0] LEN_OTP = 4'h8;
	localparam logic [3:0] LEN_STATUS = 4'h2;
	localparam logic [7:0] SUM_GOOD = 8'hFF;
	localparam int FLAG_TW = 0;
	localparam int FLAG_TSD = 1;
	localparam int FLAG_UV = 2;
	localparam int FLAG_COIL = 3;
	localparam int FLAG_MISS = 4;
	localparam int FLAG_SUPPLY = 5;
	localparam logic [5:0] FLAGS_RESET = 6'h20;
	localparam logic [15:0] POS_RESET = 16'h0000;
	localparam logic [7:0] OTP_BYTE_RESET = 8'h00;
	typedef enum {ST_IDLE, ST_RX, ST_FETCH, ST_LOAD, ST_SEND} lmc_state_t;
	typedef enum {K_PREP, K_SHORT, K_OTP, K_STATUS} lmc_kind_t;
endpackage : lmc_pkg

// file: rtl/lmc_otp_mem.sv
// Purpose: one eight-byte otp segment with registered read data
// Assumes: programming port used only while no reading frame runs
// Notes: array itself has no reset, like real fuse contents
`timescale 1ns/100ps
module lmc_otp_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge sys_clk_in) begin
		if (ce_in && wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_out <= lmc_pkg::OTP_BYTE_RESET;
		end else if (ce_in) begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule : lmc_otp_mem

// file: rtl/lmc_decoder.sv
// Purpose: command decoding for a bus-slave stepper positioner
// Assumes: transceiver delivers headers and data bytes, takes reply bytes
// Notes: motion itself lives outside; this block issues pulses and targets
// Function
// - reading frame 0x3D returns eight otp bytes in order, then checksum
// - quick status answers two bytes: switch plus address, then flags and temperature
// - serving quick status clears latched flags unless their cause persists
// - code 0x04 moves motor to stored secure position
// - secure move also on bus loss, after init, before sleep; arbitration may veto
// - two-byte commands decoded from command byte only, not identifier
// - byte one: bit7 set plus code; byte two: broadcast bit plus address
// - coil fault forces emergency stop and shutdown
// - emergency stop while moving sets missed step flag
// - after stop, actual position is copied into target position
// - code 0x05 performs emergency stop, all nodes when broadcast bit clear
// - code 0x06 clears actual and target positions
// - position clear sets reference done flag
`timescale 1ns/100ps
module lmc_decoder #(
	parameter int PW = 16,
	parameter int SW = 11
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic hdr_valid_in,
	input wire logic [7:0] hdr_pid_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	input wire logic [6:0] node_addr_in,
	input wire logic [5:0] status_id_in,
	input wire logic [5:0] short_id_in,
	input wire logic external_switch_state_in,
	input wire logic [1:0] temp_info_in,
	input wire logic thermal_warning_in,
	input wire logic thermal_shutdown_in,
	input wire logic undervoltage_in,
	input wire logic coil_fault_in,
	input wire logic missed_step_in,
	input wire logic supply_reset_in,
	input wire logic motor_moving_in,
	input wire logic [PW-1:0] actual_position_in,
	input wire logic [SW-1:0] secure_position_in,
	input wire logic lin_lost_in,
	input wire logic init_done_in,
	input wire logic sleep_req_in,
	input wire logic secure_block_in,
	input wire logic otp_wr_en_in,
	input wire logic [2:0] otp_wr_addr_in,
	input wire logic [7:0] otp_wr_data_in,
	output logic [5:0] flags_out,
	output logic [PW-1:0] target_position_out,
	output logic go_safe_position_out,
	output logic hard_stop_out,
	output logic actual_clear_out,
	output logic reference_done_out,
	output logic shutdown_out,
	output logic otp_armed_out
);
	function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		csum_add = s[7:0] + {7'h00, s[8]};
	endfunction : csum_add

	function automatic logic pid_ok(input logic [7:0] p);
		pid_ok = (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) && (p[7] == ~(p[1] ^ p[3] ^ p[4] ^ p[5]));
	endfunction : pid_ok

	lmc_pkg::lmc_state_t state, next_state;
	lmc_pkg::lmc_kind_t kind, next_kind;
	logic [3:0] idx, next_idx, len, next_len;
	logic [7:0] sum, next_sum, next_tx_data, tx_byte;
	logic [7:0] rxb [8];
	logic [7:0] next_rxb [8];
	logic next_tx_valid, next_armed, rx_last, chk_ok, addr_hit, prep_ok;
	logic cmd_goto, cmd_stop, cmd_clear, flags_clr;
	logic [7:0] mem_q;

	lmc_otp_mem #(.DEPTH(8), .AW(3)) u_otp (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.wr_en_in(otp_wr_en_in),
		.wr_addr_in(otp_wr_addr_in),
		.wr_data_in(otp_wr_data_in),
		.rd_addr_in(idx[2:0]),
		.rd_data_out(mem_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// frame engine
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_idx = idx;
		next_len = len;
		next_sum = sum;
		next_rxb = rxb;
		next_tx_valid = tx_valid_out;
		next_tx_data = tx_data_out;
		next_armed = otp_armed_out;
		cmd_goto = 1'b0;
		cmd_stop = 1'b0;
		cmd_clear = 1'b0;
		flags_clr = 1'b0;
		rx_last = (state == lmc_pkg::ST_RX) && rx_valid_in && (idx == len);
		chk_ok = csum_add(sum, rx_data_in) == lmc_pkg::SUM_GOOD;
		addr_hit = !rxb[1][7] || (rxb[1][6:0] == node_addr_in);
		prep_ok = (rxb[0] == lmc_pkg::APP_CMD) && (rxb[1] == {1'b1, lmc_pkg::CMD_OTP})
			&& (rxb[2] == {1'b1, node_addr_in}) && (rxb[3] == lmc_pkg::FILL_BYTE)
			&& (rxb[4] == lmc_pkg::FILL_BYTE) && (rxb[5] == lmc_pkg::FILL_BYTE)
			&& (rxb[6] == lmc_pkg::FILL_BYTE) && (rxb[7] == lmc_pkg::FILL_BYTE);
		if (kind == lmc_pkg::K_OTP) begin
			tx_byte = mem_q;
		end else if (idx == 4'h0) begin
			tx_byte = {external_switch_state_in, node_addr_in};
		end else begin
			tx_byte = {flags_out, temp_info_in};
		end
		unique case (state)
			lmc_pkg::ST_IDLE: begin
			end
			lmc_pkg::ST_RX: begin
				if (rx_valid_in && idx < len) begin
					next_rxb[idx[2:0]] = rx_data_in;
					next_sum = csum_add(sum, rx_data_in);
					next_idx = idx + 4'h1;
				end else if (rx_last) begin
					next_state = lmc_pkg::ST_IDLE;
					if (chk_ok && kind == lmc_pkg::K_PREP && prep_ok) begin
						next_armed = 1'b1;
					end else if (chk_ok && kind == lmc_pkg::K_SHORT && rxb[0][7]) begin
						// command byte alone selects the action
						if (rxb[0][6:0] == lmc_pkg::CMD_OTP && rxb[1] == {1'b1, node_addr_in}) begin
							next_armed = 1'b1;
						end
						cmd_goto = addr_hit && rxb[0][6:0] == lmc_pkg::CMD_SECURE;
						cmd_stop = addr_hit && rxb[0][6:0] == lmc_pkg::CMD_STOP;
						cmd_clear = addr_hit && rxb[0][6:0] == lmc_pkg::CMD_CLEAR;
					end
				end
			end
			lmc_pkg::ST_FETCH: begin
				// otp read data needs one cycle to come out of its register
				next_state = lmc_pkg::ST_LOAD;
			end
			lmc_pkg::ST_LOAD: begin
				next_tx_valid = 1'b1;
				next_state = lmc_pkg::ST_SEND;
				if (idx == len) begin
					next_tx_data = ~sum;
				end else begin
					next_tx_data = tx_byte;
					next_sum = csum_add(sum, tx_byte);
				end
			end
			lmc_pkg::ST_SEND: begin
				if (tx_ready_in) begin
					next_tx_valid = 1'b0;
					if (idx == len) begin
						next_state = lmc_pkg::ST_IDLE;
						flags_clr = kind == lmc_pkg::K_STATUS;
					end else begin
						next_idx = idx + 4'h1;
						next_state = lmc_pkg::ST_FETCH;
					end
				end
			end
		endcase
		// a new header aborts whatever frame was running
		if (hdr_valid_in) begin
			next_state = lmc_pkg::ST_IDLE;
			next_tx_valid = 1'b0;
			next_idx = 4'h0;
			if (pid_ok(hdr_pid_in)) begin
				if (hdr_pid_in[5:0] == lmc_pkg::ID_PREP) begin
					next_state = lmc_pkg::ST_RX;
					next_kind = lmc_pkg::K_PREP;
					next_len = lmc_pkg::LEN_PREP;
					next_sum = 8'h00;
				end else if (hdr_pid_in[5:0] == lmc_pkg::ID_READ && otp_armed_out) begin
					next_state = lmc_pkg::ST_FETCH;
					next_kind = lmc_pkg::K_OTP;
					next_len = lmc_pkg::LEN_OTP;
					next_sum = 8'h00;
					next_armed = 1'b0;
				end else if (hdr_pid_in[5:0] == status_id_in) begin
					next_state = lmc_pkg::ST_FETCH;
					next_kind = lmc_pkg::K_STATUS;
					next_len = lmc_pkg::LEN_STATUS;
					next_sum = hdr_pid_in;
				end else if (hdr_pid_in[5:0] == short_id_in) begin
					next_state = lmc_pkg::ST_RX;
					next_kind = lmc_pkg::K_SHORT;
					next_len = lmc_pkg::LEN_SHORT;
					next_sum = hdr_pid_in;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state <= lmc_pkg::ST_IDLE;
			kind <= lmc_pkg::K_PREP;
			idx <= 4'h0;
			len <= 4'h0;
			sum <= 8'h00;
			rxb <= '{default: 8'h00};
			tx_valid_out <= 1'b0;
			tx_data_out <= 8'h00;
			otp_armed_out <= 1'b0;
		end else if (ce_in) begin
			state <= next_state;
			kind <= next_kind;
			idx <= next_idx;
			len <= next_len;
			sum <= next_sum;
			rxb <= next_rxb;
			tx_valid_out <= next_tx_valid;
			tx_data_out <= next_tx_data;
			otp_armed_out <= next_armed;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flags and motion requests
	logic hard_stop_evt, goto_ok, wait_stop, next_wait_stop, next_shutdown, next_ref;
	logic [5:0] next_flags, flag_set;
	logic [PW-1:0] next_target;

	always_comb begin
		hard_stop_evt = cmd_stop || (coil_fault_in && !shutdown_out);
		next_shutdown = shutdown_out || coil_fault_in;
		goto_ok = (cmd_goto || lin_lost_in || init_done_in || sleep_req_in)
			&& !secure_block_in && !next_shutdown && !hard_stop_evt;
		flag_set = 6'h00;
		flag_set[lmc_pkg::FLAG_TW] = thermal_warning_in;
		flag_set[lmc_pkg::FLAG_TSD] = thermal_shutdown_in;
		flag_set[lmc_pkg::FLAG_UV] = undervoltage_in;
		flag_set[lmc_pkg::FLAG_COIL] = coil_fault_in;
		flag_set[lmc_pkg::FLAG_MISS] = missed_step_in || (hard_stop_evt && motor_moving_in);
		flag_set[lmc_pkg::FLAG_SUPPLY] = supply_reset_in;
		// a cause still present re-sets its flag in the clearing cycle
		next_flags = (flags_out & ~{6{flags_clr}}) | flag_set;
		next_wait_stop = hard_stop_evt || (wait_stop && motor_moving_in);
		next_ref = reference_done_out || cmd_clear;
		next_target = target_position_out;
		if (cmd_clear) begin
			next_target = lmc_pkg::POS_RESET;
		end else if (goto_ok) begin
			next_target = PW'(secure_position_in);
		end else if (wait_stop && !motor_moving_in) begin
			next_target = actual_position_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			flags_out <= lmc_pkg::FLAGS_RESET;
			target_position_out <= lmc_pkg::POS_RESET;
			go_safe_position_out <= 1'b0;
			hard_stop_out <= 1'b0;
			actual_clear_out <= 1'b0;
			reference_done_out <= 1'b0;
			shutdown_out <= 1'b0;
			wait_stop <= 1'b0;
		end else if (ce_in) begin
			flags_out <= next_flags;
			target_position_out <= next_target;
			go_safe_position_out <= goto_ok;
			hard_stop_out <= hard_stop_evt;
			actual_clear_out <= cmd_clear;
			reference_done_out <= next_ref;
			shutdown_out <= next_shutdown;
			wait_stop <= next_wait_stop;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && flags_clr && !undervoltage_in |=> !flags_out[lmc_pkg::FLAG_UV])
		else $error("status read did not clear undervoltage flag");
	flag_keep_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && thermal_warning_in |=> flags_out[lmc_pkg::FLAG_TW])
		else $error("persistent warning cause lost its flag");
	pos_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && cmd_clear |=> target_position_out == lmc_pkg::POS_RESET
		&& actual_clear_out && reference_done_out)
		else $error("position clear incomplete");
	coil_stop_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && coil_fault_in && !shutdown_out |=> hard_stop_out && shutdown_out)
		else $error("coil fault without stop and shutdown");
	step_loss_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && hard_stop_evt && motor_moving_in |=> flags_out[lmc_pkg::FLAG_MISS])
		else $error("stop while moving did not flag missed steps");
	hold_pos_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && wait_stop && !motor_moving_in && !cmd_clear && !goto_ok
		|=> target_position_out == $past(actual_position_in))
		else $error("stop position not copied to target");
	secure_move_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ce_in && goto_ok && !cmd_clear
		|=> go_safe_position_out && target_position_out == PW'($past(secure_position_in)))
		else $error("secure move not issued");
	bad_sum_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		(cmd_goto || cmd_stop || cmd_clear) |-> rx_last && chk_ok)
		else $error("command taken from frame with bad checksum");
	tx_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		tx_valid_out && !tx_ready_in && !hdr_valid_in |=> tx_valid_out && $stable(tx_data_out))
		else $error("reply byte dropped before accepted");
endmodule : lmc_decoder

// file: testbench/lmc_master_model.sv
// Purpose: byte-level bus master that sends frames and takes reply bytes
// Assumes: one transfer at a time, driven from the bench top
// Notes: idle data lines show the inverse of the last byte, never a held value
`timescale 1ns/100ps
module lmc_master_model (
	input wire logic sys_clk_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic hdr_valid_out,
	output logic [7:0] hdr_pid_out,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic tx_ready_out
);
	logic [7:0] got [10];
	initial begin
		{hdr_valid_out, rx_valid_out, tx_ready_out} = 3'b000;
		{hdr_pid_out, rx_data_out} = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction : pid
	function automatic logic [7:0] csum(input logic [7:0] s0, input logic [7:0] d [10], input int n);
		logic [8:0] s;
		s = {1'b0, s0};
		for (int i = 0; i < n; i++) begin
			s = s[7:0] + d[i];
			s = s[7:0] + s[8];
		end
		return ~s[7:0];
	endfunction : csum
	task automatic header(input logic [5:0] id);
		@(posedge sys_clk_in);
		hdr_valid_out <= 1'b1;
		hdr_pid_out <= pid(id);
		@(posedge sys_clk_in);
		hdr_valid_out <= 1'b0;
		hdr_pid_out <= ~pid(id);
	endtask : header
	// writing frame: data bytes then checksum, optionally corrupted
	task automatic send(input logic [5:0] id, input logic [7:0] d [10], input int n,
		input logic enh, input logic bad);
		header(id);
		for (int i = 0; i <= n; i++) begin
			rx_valid_out <= 1'b1;
			rx_data_out <= (i == n) ? csum(enh ? pid(id) : 8'h00, d, n) ^ {7'h00, bad} : d[i];
			@(posedge sys_clk_in);
		end
		rx_valid_out <= 1'b0;
		rx_data_out <= ~rx_data_out;
	endtask : send
	// reading frame; slow takes only every other cycle
	task automatic recv(input logic [5:0] id, input int n, input logic slow, output int cnt);
		header(id);
		cnt = 0;
		for (int w = 0; w < 100 && cnt < n; w++) begin
			tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
			@(negedge sys_clk_in);
			if (tx_valid_in && tx_ready_out) begin
				got[cnt] = tx_data_in;
				cnt++;
			end
			@(posedge sys_clk_in);
		end
		tx_ready_out <= 1'b0;
	endtask : recv
endmodule : lmc_master_model

// file: testbench/tb.sv
// Purpose: self-checking bench for the motor command decoder
// Assumes: clock enable held high except for one short low window; byte timing comes from the master model
// Notes: pulses are counted at the falling edge, clear of the launching edge
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	logic sys_clk_in, sys_rst_in, ce_in, hdr_valid_in, rx_valid_in, tx_ready_in, tx_valid_out;
	logic [7:0] hdr_pid_in, rx_data_in, tx_data_out, otp_wr_data_in, b2;
	logic [6:0] node_addr_in;
	logic [5:0] status_id_in, short_id_in, flags_out;
	logic [1:0] temp_info_in;
	logic external_switch_state_in, thermal_warning_in, thermal_shutdown_in, undervoltage_in;
	logic coil_fault_in, missed_step_in, supply_reset_in, motor_moving_in, lin_lost_in;
	logic init_done_in, sleep_req_in, secure_block_in, otp_wr_en_in, go_safe_position_out;
	logic hard_stop_out, actual_clear_out, reference_done_out, shutdown_out, otp_armed_out;
	logic [15:0] actual_position_in, target_position_out, exp_tgt;
	logic [10:0] secure_position_in;
	logic [2:0] otp_wr_addr_in;
	logic [7:0] fr [10];
	logic [7:0] otp [10];
	int seed, fails, tests_run, cyc, n, snap;
	int hits [3];
	lmc_decoder dut (.sys_clk_in, .sys_rst_in, .ce_in, .hdr_valid_in, .hdr_pid_in, .rx_valid_in,
		.rx_data_in, .tx_ready_in, .tx_valid_out, .tx_data_out, .node_addr_in, .status_id_in,
		.short_id_in, .external_switch_state_in, .temp_info_in, .thermal_warning_in,
		.thermal_shutdown_in, .undervoltage_in, .coil_fault_in, .missed_step_in,
		.supply_reset_in, .motor_moving_in, .actual_position_in, .secure_position_in,
		.lin_lost_in, .init_done_in, .sleep_req_in, .secure_block_in, .otp_wr_en_in,
		.otp_wr_addr_in, .otp_wr_data_in, .flags_out, .target_position_out,
		.go_safe_position_out, .hard_stop_out, .actual_clear_out, .reference_done_out,
		.shutdown_out, .otp_armed_out);
	lmc_master_model master (.sys_clk_in, .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
		.hdr_valid_out(hdr_valid_in), .hdr_pid_out(hdr_pid_in), .rx_valid_out(rx_valid_in),
		.rx_data_out(rx_data_in), .tx_ready_out(tx_ready_in));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	always @(negedge sys_clk_in) begin
		hits[0] += go_safe_position_out;
		hits[1] += hard_stop_out;
		hits[2] += actual_clear_out;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (fails == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	function automatic int hit(input logic [7:0] b);
		return int'(b[7] === 1'b0 || b[6:0] === node_addr_in);
	endfunction : hit
	task automatic frame(input logic [5:0] id, input int len, input logic enh, input logic bad);
		master.send(id, fr, len, enh, bad);
		repeat (3) @(posedge sys_clk_in);
	endtask : frame
	task automatic cmd(input logic [6:0] code, input logic [7:0] b, input logic bad);
		fr[0] = {1'b1, code};
		fr[1] = b;
		frame(short_id_in, 2, 1'b1, bad);
	endtask : cmd
	task automatic status_check(input logic [5:0] f);
		master.recv(status_id_in, 3, 1'b1, n);
		fr[0] = {external_switch_state_in, node_addr_in};
		fr[1] = {f, temp_info_in};
		`CHK(master.got[0], fr[0])
		`CHK(master.got[1], fr[1])
		`CHK(master.got[2], master.csum(master.pid(status_id_in), fr, 2))
		repeat (2) @(posedge sys_clk_in);
	endtask : status_check
	task automatic otp_read(input logic slow);
		master.recv(lmc_pkg::ID_READ, 9, slow, n);
		`CHK(n, 9)
		for (int i = 0; i < 8; i++) `CHK(master.got[i], otp[i])
		`CHK(master.got[8], master.csum(8'h00, otp, 8))
		`CHK(otp_armed_out, 1'b0)
	endtask : otp_read
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h51c6;
		sys_rst_in = 1'b1;
		ce_in = 1'b1;
		{thermal_warning_in, thermal_shutdown_in, undervoltage_in, coil_fault_in, missed_step_in,
			supply_reset_in, motor_moving_in, lin_lost_in, init_done_in, sleep_req_in,
			secure_block_in, otp_wr_en_in, otp_wr_addr_in, otp_wr_data_in} = '0;
		node_addr_in = 7'($random(seed));
		status_id_in = {2'b00, 4'($random(seed))};
		short_id_in = {2'b10, 4'($random(seed))};
		external_switch_state_in = 1'($random(seed));
		temp_info_in = 2'($random(seed));
		secure_position_in = 11'($random(seed));
		actual_position_in = 16'($random(seed));
		repeat (12) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge sys_clk_in);
		`CHK(flags_out, 6'h20)
		for (int i = 0; i < 8; i++) begin
			otp[i] = 8'($random(seed));
			otp_wr_en_in <= 1'b1;
			otp_wr_addr_in <= 3'(i);
			otp_wr_data_in <= otp[i];
			@(posedge sys_clk_in);
		end
		otp_wr_en_in <= 1'b0;
		status_check(6'h20);
		`CHK(flags_out, 6'h00)
		exp_tgt = 16'h0000;
		// own address, foreign address, then broadcast for each command
		for (int k = 0; k < 3; k++) begin
			for (int v = 0; v < 3; v++) begin
				b2 = (v == 0) ? {1'b1, node_addr_in} : {v[0], node_addr_in + 7'h03};
				snap = hits[k];
				cmd(7'h04 + 7'(k), b2, 1'b0);
				if (hit(b2) == 1) exp_tgt = (k == 0) ? {5'h00, secure_position_in} :
					(k == 1) ? actual_position_in : 16'h0000;
				`CHK(hits[k] - snap, hit(b2))
				`CHK(target_position_out, exp_tgt)
			end
		end
		`CHK(reference_done_out, 1'b1)
		snap = hits[0];
		cmd(7'h04, {1'b1, node_addr_in}, 1'b1);
		`CHK(hits[0] - snap, 0)
		motor_moving_in <= 1'b1;
		cmd(7'h05, 8'h00, 1'b0);
		`CHK(flags_out[4], 1'b1)
		motor_moving_in <= 1'b0;
		actual_position_in <= 16'($random(seed));
		repeat (3) @(posedge sys_clk_in);
		`CHK(target_position_out, actual_position_in)
		// internal triggers, then the same with the arbitration veto up
		for (int i = 0; i < 6; i++) begin
			snap = hits[0];
			secure_block_in <= (i > 2);
			{lin_lost_in, init_done_in, sleep_req_in} <= 3'b100 >> (i % 3);
			@(posedge sys_clk_in);
			{lin_lost_in, init_done_in, sleep_req_in} <= 3'b000;
			repeat (3) @(posedge sys_clk_in);
			`CHK(hits[0] - snap, int'(i < 3))
		end
		// a trigger seen while the clock enable is low must leave no trace
		snap = hits[0];
		ce_in <= 1'b0;
		lin_lost_in <= 1'b1;
		@(posedge sys_clk_in);
		lin_lost_in <= 1'b0;
		@(posedge sys_clk_in);
		ce_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		`CHK(hits[0] - snap, 0)
		secure_block_in <= 1'b0;
		{undervoltage_in, thermal_warning_in} <= 2'b11;
		repeat (2) @(posedge sys_clk_in);
		status_check(6'h15);
		`CHK(flags_out, 6'h05)
		{undervoltage_in, thermal_warning_in} <= 2'b00;
		master.recv(lmc_pkg::ID_READ, 9, 1'b0, n);
		`CHK(n, 0)
		fr = '{8'h80, 8'h82, {1'b1, node_addr_in}, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h00};
		frame(lmc_pkg::ID_PREP, 8, 1'b0, 1'b0);
		`CHK(otp_armed_out, 1'b0)
		fr[7] = 8'hFF;
		frame(lmc_pkg::ID_PREP, 8, 1'b0, 1'b0);
		`CHK(otp_armed_out, 1'b1)
		otp_read(1'b1);
		cmd(lmc_pkg::CMD_OTP, {1'b1, node_addr_in}, 1'b0);
		`CHK(otp_armed_out, 1'b1)
		otp_read(1'b0);
		snap = hits[1];
		coil_fault_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		`CHK(hits[1] - snap, 1)
		`CHK(shutdown_out, 1'b1)
		// mid-run reset: only reset releases the latched shutdown and reference flag
		coil_fault_in <= 1'b0;
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge sys_clk_in);
		`CHK(shutdown_out, 1'b0)
		`CHK(reference_done_out, 1'b0)
		`CHK(flags_out, 6'h20)
		complete_run();
	end
endmodule : tb
